// >>> design/pcmc_codec_ctrl.sv
// digital side of a telephone voice codec: pcm port, settings
// assumes: pins asynchronous to clk_sys_in, link clock sampled
`timescale 1ns/1ps
`include "pcmc_cfg.svh"
// Behaviour
// RULE_01: strobe marks the eight-bit slot both ways
// RULE_02: delayed eight-bit strobe after strobe falls
// RULE_03: delayed frame pulse four channels later
// RULE_04: fast bit clock feeds master clock
// RULE_05: slow bit clock needs 4096 kHz master
// RULE_06: reset: sidetone off, 0 dB, mu-law
// RULE_07: reset: strobed mode, 2048 kb/s, powered
// RULE_08: tx gain code 0..7 dB up
// RULE_09: rx gain code 0..7 dB down
// RULE_10: both filter gains at address 00h
// RULE_11: sidetone gain in 3.32 dB steps
// RULE_12: sidetone enable and gain at 01h
// RULE_13: law is register bit OR pin
// RULE_14: law and coding bits at 04h
// RULE_15: positive full scale code points
// RULE_16: positive zero code points
// RULE_17: negative zero is the quiet code
// RULE_18: negative full scale code points
// RULE_19: one word each way per sample
// RULE_20: law pin becomes interrupt when enabled
// RULE_21: shift out rising, sample falling edge; tdm mode shifts out falling and samples rising
// RULE_22: mute bits at 03h force quiet code
// RULE_23: data output released outside the slot
// RULE_24: new settings apply next sample period
module pcmc_codec_ctrl (
  input  wire logic                  clk_sys_in,
  input  wire logic                  sys_rst_in,
  input  wire logic                  clk_en_in,
  input  wire logic                  power_up_reset_n_in,
  input  wire logic                  master_clock_in,
  input  wire logic                  slot_strobe_frame_pulse_in,
  input  wire logic                  pcm_din_in,
  output logic                       pcm_dout_out,
  output logic                       pcm_dout_oe_n_out,
  output logic                       delayed_strobe_frame_out,
  input  wire logic                  law_pin_in,
  output logic                       law_pin_out,
  output logic                       law_pin_oe_n_out,
  input  wire pcmc_pkg::pcmc_reg_req_t reg_req_in,
  output logic [7:0]                 reg_rdata_out,
  input  wire logic                  tx_valid_in,
  output logic                       tx_ready_out,
  input  wire logic [7:0]            tx_sample_in,
  output logic                       rx_valid_out,
  output logic [7:0]                 rx_sample_out,
  output pcmc_pkg::pcmc_cfg_t        cfg_out
);
  import pcmc_pkg::*;

  logic [4:0]  meta_q;
  logic [4:0]  sync_q;
  logic        bclk_prev_q;
  logic        stb_prev_q;
  logic [7:0]  fgc_q;
  logic [7:0]  sgc_q;
  logic [7:0]  qct_q;
  logic [7:0]  lpc_q;
  logic        irq_q;
  pcmc_cfg_t   cfg_q;
  pcmc_cfg_t   cfg_live;
  pcmc_slot_t  slot_q;
  logic [8:0]  cnt_q;
  logic [8:0]  pos;
  logic [7:0]  tx_sh_q;
  logic [7:0]  rx_sh_q;
  logic [2:0]  rbit_q;
  logic [2:0]  dcnt_q;
  logic        dout_q;
  logic        oe_n_q;
  logic        dly_q;
  logic        rxv_q;
  logic [7:0]  rxd_q;
  logic        power_up_reset_n_n_s;
  logic        bclk_s;
  logic        stb_s;
  logic        din_s;
  logic        lawpin_s;
  logic        bclk_rise;
  logic        bclk_fall;
  logic        tdm;
  logic        signalling_channel_enable;
  logic        own_pos;
  logic        own_cnt;
  logic        tx_load;
  logic        tx_shift;
  logic        tx_off;
  logic        rx_take;
  logic        rx_done;
  logic        frame_start;
  logic        fifo_valid;
  logic [7:0]  fifo_data;
  logic [7:0]  tx_word;
  logic [7:0]  rx_word;

  // xor mask that turns sign-magnitude into the selected code
  function automatic logic [7:0] code_mask(input pcmc_cfg_t c);
    code_mask = c.smag ? `PCMC_MASK_SM :
                c.alaw ? `PCMC_MASK_A : `PCMC_MASK_MU; // RULE_18
  endfunction

  // ----------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------
  // order: law pin, data in, strobe, bit clock, power-up reset
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    if (sys_rst_in)
    begin
      meta_q <= 5'h01;
      sync_q <= 5'h01;
    end
    else if (clk_en_in)
    begin
      meta_q <= {law_pin_in, pcm_din_in, slot_strobe_frame_pulse_in,
                 master_clock_in, power_up_reset_n_in};
      sync_q <= meta_q;
    end

  assign power_up_reset_n_n_s = sync_q[0];
  assign bclk_s    = sync_q[1];
  assign stb_s     = sync_q[2];
  assign din_s     = sync_q[3];
  assign lawpin_s  = sync_q[4];

  // edges of the sampled link clock; needs >= 4 samples per cycle
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    if (sys_rst_in)
      bclk_prev_q <= 1'b0;
    else if (clk_en_in)
      bclk_prev_q <= bclk_s;                               // RULE_04

  assign bclk_rise = bclk_s && !bclk_prev_q;
  assign bclk_fall = !bclk_s && bclk_prev_q;

  // ----------------------------------------------------------
  // registers
  // ----------------------------------------------------------
  // power-up reset pin restores defaults as a synchronous clear
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    if (sys_rst_in)
    begin
      fgc_q <= `PCMC_FGC_RST;
      sgc_q <= `PCMC_SGC_RST;
      qct_q <= `PCMC_QCT_RST;
      lpc_q <= `PCMC_LPC_RST;
    end
    else if (clk_en_in)
    begin
      if (!power_up_reset_n_n_s)
      begin
        fgc_q <= `PCMC_FGC_RST;                            // RULE_06
        sgc_q <= `PCMC_SGC_RST;                            // RULE_06
        qct_q <= `PCMC_QCT_RST;
        lpc_q <= `PCMC_LPC_RST;                            // RULE_07
      end
      else if (reg_req_in.wr)
        case (reg_req_in.addr)
          `PCMC_FGC_ADDR: fgc_q <= reg_req_in.wdata & 8'h77;  // RULE_10
          `PCMC_SGC_ADDR: sgc_q <= reg_req_in.wdata & 8'h0f;  // RULE_12
          `PCMC_QCT_ADDR: qct_q <= reg_req_in.wdata & 8'h03;  // RULE_22
          `PCMC_LPC_ADDR: lpc_q <= reg_req_in.wdata;          // RULE_14
          default: ;
        endcase
    end

  assign tdm = (lpc_q[`PCMC_MODE_LSB +: 3] == `PCMC_MODE_TDM);
  assign signalling_channel_enable = lpc_q[`PCMC_DEN_BIT];

  // read answer one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    if (sys_rst_in)
      reg_rdata_out <= 8'h00;
    else if (clk_en_in && reg_req_in.rd)
      case (reg_req_in.addr)
        `PCMC_FGC_ADDR: reg_rdata_out <= fgc_q;
        `PCMC_SGC_ADDR: reg_rdata_out <= sgc_q;
        `PCMC_QCT_ADDR: reg_rdata_out <= qct_q;
        `PCMC_LPC_ADDR: reg_rdata_out <= lpc_q;
        `PCMC_STS_ADDR: reg_rdata_out <= {4'h0, slot_q == PCMC_SLOT_DONE,
                                          irq_q, !fifo_valid,
                                          cfg_q.alaw};
        default:        reg_rdata_out <= 8'h00;
      endcase

  // ----------------------------------------------------------
  // settings applied per sample period
  // ----------------------------------------------------------
  always_comb
  begin
    cfg_live.tx_gain = fgc_q[`PCMC_TXG_LSB +: 3];           // RULE_08
    cfg_live.rx_gain = fgc_q[`PCMC_RXG_LSB +: 3];           // RULE_09
    cfg_live.st_gain = sgc_q[`PCMC_STG_LSB +: 3];           // RULE_11
    cfg_live.st_en   = sgc_q[`PCMC_STEN_BIT];               // RULE_12
    cfg_live.alaw    = lpc_q[`PCMC_LAW_BIT] | (lawpin_s & !signalling_channel_enable); // RULE_13
    cfg_live.smag    = lpc_q[`PCMC_COD_BIT];                // RULE_14
  end

  // latched at frame start so a word never mixes two settings
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    if (sys_rst_in)
      cfg_q <= '0;
    else if (clk_en_in && frame_start)
      cfg_q <= cfg_live;                                   // RULE_24

  assign cfg_out = cfg_q;

  // ----------------------------------------------------------
  // slot timing
  // ----------------------------------------------------------
  // tdm: frame pulse low at a falling clock edge restarts count
  assign pos     = !stb_s ? 9'h000 : cnt_q + 9'h001;
  assign own_pos = (pos[8:4] == `PCMC_OWN_CHAN);
  assign own_cnt = (cnt_q[8:4] == `PCMC_OWN_CHAN);

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    if (sys_rst_in)
      cnt_q <= 9'h1ff;
    else if (clk_en_in && tdm && bclk_fall)
      cnt_q <= pos;                                        // RULE_03

  always_comb
  begin
    if (tdm)
    begin
      tx_load     = bclk_fall && own_pos && (pos[3:0] == 4'h0);
      tx_shift    = bclk_fall && own_pos && !pos[0] && (pos[3:1] != 3'h0);
      tx_off      = bclk_fall && !own_pos;
      rx_take     = bclk_rise && own_cnt && cnt_q[0];
      frame_start = bclk_fall && !stb_s;
    end
    else
    begin
      tx_load     = bclk_rise && stb_s && (slot_q == PCMC_SLOT_IDLE);
      tx_shift    = bclk_rise && stb_s && (slot_q != PCMC_SLOT_IDLE);
      tx_off      = bclk_rise && !stb_s;                   // RULE_23
      rx_take     = bclk_fall && stb_s && (slot_q == PCMC_SLOT_SHIFT);
      frame_start = tx_load;                               // RULE_01
    end
  end

  assign rx_done = rx_take && (rbit_q == `PCMC_BITS_LAST);

  // strobed slot sequence: load, eight bits, wait for strobe low
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    if (sys_rst_in)
      slot_q <= PCMC_SLOT_IDLE;
    else if (clk_en_in)
      case (slot_q)
        PCMC_SLOT_IDLE:  if (!tdm && tx_load) slot_q <= PCMC_SLOT_SHIFT;
        PCMC_SLOT_SHIFT: if (tdm || tx_off) slot_q <= PCMC_SLOT_IDLE;
                         else if (rx_done) slot_q <= PCMC_SLOT_DONE;
        PCMC_SLOT_DONE:  if (tdm || tx_off) slot_q <= PCMC_SLOT_IDLE;
        default:         slot_q <= PCMC_SLOT_IDLE;
      endcase

  // ----------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------
  // empty fifo or mute sends quiet code instead of stale data
  assign tx_word = ((fifo_valid && !qct_q[`PCMC_TXQ_BIT]) ? fifo_data
                    : `PCMC_QUIET_SM) ^ code_mask(cfg_live); // RULE_22

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    if (sys_rst_in)
    begin
      tx_sh_q <= 8'h00;
      dout_q  <= 1'b0;
      oe_n_q  <= 1'b1;
    end
    else if (clk_en_in)
    begin
      if (tx_load)
      begin
        tx_sh_q <= tx_word;                                // RULE_15
        dout_q  <= tx_word[7];                             // RULE_21
        oe_n_q  <= 1'b0;
      end
      else if (tx_shift)
      begin
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
        dout_q  <= tx_sh_q[6];                             // RULE_21
      end
      else if (tx_off)
        oe_n_q <= 1'b1;                                    // RULE_23
    end

  assign pcm_dout_out      = dout_q;
  assign pcm_dout_oe_n_out = oe_n_q;

  pcmc_fifo #(
    .W (8),
    .D (16)
  ) u_tx_fifo (
    .clk_in        (clk_sys_in),
    .rst_in        (sys_rst_in),
    .en_in         (clk_en_in),
    .in_valid_in   (tx_valid_in),
    .in_ready_out  (tx_ready_out),
    .in_data_in    (tx_sample_in),
    .out_valid_out (fifo_valid),
    .out_ready_in  (tx_load),                              // RULE_19
    .out_data_out  (fifo_data)
  );

  // ----------------------------------------------------------
  // receive path
  // ----------------------------------------------------------
  assign rx_word = qct_q[`PCMC_RXQ_BIT] ? `PCMC_QUIET_SM
                   : {rx_sh_q[6:0], din_s} ^ code_mask(cfg_q); // RULE_16

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    if (sys_rst_in)
    begin
      rx_sh_q <= 8'h00;
      rbit_q  <= 3'h0;
      rxv_q   <= 1'b0;
      rxd_q   <= 8'h00;
    end
    else if (clk_en_in)
    begin
      rxv_q <= rx_done;                                    // RULE_19
      if (tx_load)
        rbit_q <= 3'h0;
      else if (rx_take)
      begin
        rx_sh_q <= {rx_sh_q[6:0], din_s};                  // RULE_21
        rbit_q  <= rbit_q + 3'h1;
      end
      if (rx_done)
        rxd_q <= rx_word;                                  // RULE_17
    end

  assign rx_valid_out  = rxv_q;
  assign rx_sample_out = rxd_q;

  // ----------------------------------------------------------
  // delayed strobe or frame pulse for cascading
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    if (sys_rst_in)
    begin
      stb_prev_q <= 1'b0;
      dcnt_q     <= 3'h0;
      dly_q      <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (tdm && bclk_fall)
        dly_q <= (pos != `PCMC_DLY_POS);                   // RULE_03
      else if (!tdm && bclk_rise)
      begin
        stb_prev_q <= stb_s;
        if (stb_prev_q && !stb_s)
        begin
          dcnt_q <= `PCMC_DLY_BITS;                        // RULE_02
          dly_q  <= 1'b1;
        end
        else
        begin
          dly_q  <= (dcnt_q != 3'h0);
          dcnt_q <= (dcnt_q != 3'h0) ? dcnt_q - 3'h1 : 3'h0;
        end
      end
    end

  assign delayed_strobe_frame_out = dly_q;

  // ----------------------------------------------------------
  // law pin as interrupt output
  // ----------------------------------------------------------
  // set wins over the clearing status read
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    if (sys_rst_in)
    begin
      irq_q            <= 1'b0;
      law_pin_oe_n_out <= 1'b1;
    end
    else if (clk_en_in)
    begin
      if (rx_done && signalling_channel_enable)
        irq_q <= 1'b1;
      else if (reg_req_in.rd && reg_req_in.addr == `PCMC_STS_ADDR)
        irq_q <= 1'b0;
      law_pin_oe_n_out <= !(signalling_channel_enable && irq_q);                 // RULE_20
    end

  assign law_pin_out = 1'b0;

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  por_defaults_a: assert property (clk_en_in && !power_up_reset_n_n_s |=> // RULE_06
    fgc_q == `PCMC_FGC_RST && sgc_q == `PCMC_SGC_RST
    && lpc_q == `PCMC_LPC_RST && !tdm)                      // RULE_07
    else $error("power-up reset did not restore defaults");
  tx_mute_quiet_a: assert property (clk_en_in && tx_load     // RULE_22
    && qct_q[`PCMC_TXQ_BIT] |=> tx_sh_q == $past(code_mask(cfg_live)))
    else $error("muted transmit word is not quiet code");
  tx_encode_a: assert property (clk_en_in && tx_load && fifo_valid // RULE_15
    && !qct_q[`PCMC_TXQ_BIT] |=>
    tx_sh_q == ($past(fifo_data) ^ $past(code_mask(cfg_live))))
    else $error("transmit word badly encoded");
  slot_release_a: assert property (clk_en_in && tx_off |=>  // RULE_23
    pcm_dout_oe_n_out)
    else $error("data output driven outside slot");
  cfg_apply_a: assert property (clk_en_in && frame_start |=> // RULE_24
    cfg_out.alaw == $past(lpc_q[`PCMC_LAW_BIT] | (lawpin_s & !signalling_channel_enable)))
    else $error("law setting not applied at frame start");
  ssi_delay_a: assert property (clk_en_in && !tdm && bclk_rise // RULE_02
    && stb_prev_q && !stb_s |=> delayed_strobe_frame_out)
    else $error("delayed strobe missing after strobe fall");
  tdm_delay_a: assert property (clk_en_in && tdm && bclk_fall // RULE_03
    && pos == `PCMC_DLY_POS |=> !delayed_strobe_frame_out)
    else $error("delayed frame pulse missing at channel four");
  rx_word_a: assert property (rx_valid_out |->              // RULE_19
    $past(rx_take) && $past(rbit_q) == `PCMC_BITS_LAST)
    else $error("receive word without its eighth bit");
  irq_pin_a: assert property (clk_en_in && !signalling_channel_enable |=>         // RULE_20
    law_pin_oe_n_out)
    else $error("law pin driven while used as input");

  ssi_word_c: cover property (!tdm && rx_valid_out);
  tdm_word_c: cover property (tdm && rx_valid_out);
  tdm_pulse_c: cover property (tdm && !delayed_strobe_frame_out);
  fifo_full_c: cover property (!tx_ready_out);
endmodule

// >>> include/pcmc_cfg.svh
// register map, field positions, reset values and link counts
// assumes: included by bare name from design files
`ifndef PCMC_CFG_SVH
`define PCMC_CFG_SVH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define PCMC_FGC_ADDR 8'h00
`define PCMC_SGC_ADDR 8'h01
`define PCMC_QCT_ADDR 8'h03
`define PCMC_LPC_ADDR 8'h04
`define PCMC_STS_ADDR 8'h05
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PCMC_TXG_LSB  0
`define PCMC_RXG_LSB  4
`define PCMC_STG_LSB  0
`define PCMC_STEN_BIT 3
`define PCMC_RXQ_BIT  0
`define PCMC_TXQ_BIT  1
`define PCMC_LAW_BIT  0
`define PCMC_COD_BIT  1
`define PCMC_MODE_LSB 2
`define PCMC_DEN_BIT  5
`define PCMC_RATE_LSB 6
// ------------------------------------------------------------
// reset values and encodings
// ------------------------------------------------------------
`define PCMC_FGC_RST  8'h00
`define PCMC_SGC_RST  8'h03
`define PCMC_QCT_RST  8'h00
`define PCMC_LPC_RST  8'hc0
`define PCMC_MODE_TDM 3'h7
`define PCMC_MASK_SM  8'h00
`define PCMC_MASK_MU  8'h7f
`define PCMC_MASK_A   8'h55
`define PCMC_QUIET_SM 8'h00
// ------------------------------------------------------------
// link timing counts
// ------------------------------------------------------------
`define PCMC_BITS_LAST 3'h7
`define PCMC_DLY_POS   9'h040
`define PCMC_OWN_CHAN  5'h02
`define PCMC_DLY_BITS  3'h7
`endif

// >>> include/pcmc_pkg.sv
// shared types of the pcm codec control block
// assumes: nothing beyond the standard language
package pcmc_pkg;
  // slot sequence of the strobed port, gray along the path
  typedef enum logic [1:0]
  {
    PCMC_SLOT_IDLE  = 2'b00,
    PCMC_SLOT_SHIFT = 2'b01,
    PCMC_SLOT_DONE  = 2'b11
  } pcmc_slot_t;

  // settings handed to the analog path, applied per sample
  typedef struct packed
  {
    logic [2:0] tx_gain;
    logic [2:0] rx_gain;
    logic [2:0] st_gain;
    logic       st_en;
    logic       alaw;
    logic       smag;
  } pcmc_cfg_t;

  // register read or write request
  typedef struct packed
  {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcmc_reg_req_t;
endpackage

// >>> design/pcmc_fifo.sv
// parameterised fifo with valid/ready on both sides
// assumes: one clock, async high reset, enable freezes state
`timescale 1ns/1ps
module pcmc_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         en_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [CW-1:0] cnt_q;
  logic          full_q;
  logic          push;
  logic          pop;

  assign push          = in_valid_in && !full_q;
  assign pop           = out_ready_in && (cnt_q != '0);
  assign in_ready_out  = !full_q;
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out  = mem_q[rp_q];

  // ----------------------------------------------------------
  // storage
  // ----------------------------------------------------------
  // array has no reset: contents are only read when counted
  always_ff @(posedge clk_in)
    if (en_in && push)
      mem_q[wp_q] <= in_data_in;

  // ----------------------------------------------------------
  // pointers and level
  // ----------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      wp_q   <= '0;
      rp_q   <= '0;
      cnt_q  <= '0;
      full_q <= 1'b0;
    end
    else if (en_in)
    begin
      if (push)
        wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
      if (pop)
        rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
      if (push && !pop)
      begin
        cnt_q  <= cnt_q + 1'b1;
        full_q <= (cnt_q == CW'(D - 1));
      end
      else if (pop && !push)
      begin
        cnt_q  <= cnt_q - 1'b1;
        full_q <= 1'b0;
      end
    end

  fifo_no_overflow_a: assert property (@(posedge clk_in)
    disable iff (rst_in) full_q |-> cnt_q == CW'(D))
    else $error("fifo full flag disagrees with level");
endmodule

// >>> dv/pcmc_l1_model.sv
// layer 1 partner on the serial pcm port, in strobed and in tdm mode
// assumes: frame task spaces its own slots; bit clock idles low between slots
`timescale 1ns/1ps
module pcmc_l1_model (
  output logic      bclk_out,
  output logic      strobe_out,
  output logic      din_out,
  input  wire logic dout_in,
  input  wire logic oe_n_in,
  input  wire logic dly_in
);
  initial
  begin
    bclk_out = 1'b0;
    strobe_out = 1'b0;
    din_out = 1'b0;
  end

  // one slot, then ten rises with strobe low for the delayed strobe;
  // dout is sampled late in the cycle because the dut syncs the clock
  task automatic frame(input logic [7:0] tx, output logic [7:0] rx,
                       output logic [7:0] dly_n, output logic [7:0] drv_n);
    int i;
    rx = 8'h00;
    dly_n = 8'h00;
    drv_n = 8'h00;
    strobe_out <= 1'b1;
    #100;
    for (i = 0; i < 18; i++)
    begin
      bclk_out <= 1'b1;
      din_out <= (i < 8) ? tx[7-i] : ~din_out;
      #100;
      bclk_out <= 1'b0;
      #50;
      if (i == 7) strobe_out <= 1'b0;
      #45;
      // a released line reads as the inverse of its last level
      if (i < 8) rx[7-i] = dout_in ^ oe_n_in;
      dly_n += (i >= 8) ? {7'h00, dly_in} : 8'h00;
      drv_n += (i >= 8) ? {7'h00, ~oe_n_in} : 8'h00;
      #5;
    end
    // one slot per 125 us
    #121300;
  endtask

  // tdm: frame pulse low across the second falling clock edge, then
  // counts samples with the delayed pulse low and with dout driven
  task automatic tdm_frame(output logic [7:0] dly_n,
                           output logic [7:0] drv_n);
    int i;
    dly_n = 8'h00;
    drv_n = 8'h00;
    for (i = 0; i < 72; i++)
    begin
      bclk_out <= 1'b1;
      strobe_out <= (i != 1);
      #100;
      bclk_out <= 1'b0;
      #95;
      dly_n += {7'h00, ~dly_in};
      drv_n += {7'h00, ~oe_n_in};
      #5;
    end
  endtask
endmodule

// >>> dv/tb_top.sv
// self-checking bench of the pcm codec control block
// assumes: partner model drives the link pins
`timescale 1ns/1ps
module tb_top;
  import pcmc_pkg::*;
  logic          clk_sys_in = 1'b0;
  logic          sys_rst_in = 1'b1;
  logic          pwr_n      = 1'b1;
  logic          law_pin    = 1'b0;
  logic          tx_valid   = 1'b0;
  logic [7:0]    tx_sample  = 8'h00;
  pcmc_reg_req_t req        = '0;
  logic          bclk, strobe, din, dout, oe_n, dly, lp_oe_n, lp_o;
  logic          rx_valid, tx_ready;
  logic [7:0]    rdata, rx_sample, got, dly_n, drv_n;
  pcmc_cfg_t     cfg;
  int            num_errors = 0;
  int            samples_checked = 0;
  int            cycles = 0;
  int            rx_cnt = 0;
  int            k, n;
  logic [7:0] lpc [6] = '{8'hc2, 8'hc0, 8'hc1, 8'hc0, 8'hc2, 8'hc0};
  logic       pin [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  logic [7:0] txw [6] = '{8'hff, 8'hff, 8'hff, 8'h00, 8'h7f, 8'h7f};
  logic [7:0] txe [6] = '{8'hff, 8'h80, 8'haa, 8'h55, 8'h7f, 8'h7f};
  logic [7:0] rxw [6] = '{8'h80, 8'hff, 8'hd5, 8'h2a, 8'h00, 8'h00};
  logic [7:0] rxe [6] = '{8'h80, 8'h80, 8'h80, 8'h7f, 8'h00, 8'h00};
  logic       law [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

  always #12.5 clk_sys_in = ~clk_sys_in;

  pcmc_codec_ctrl dut (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .clk_en_in(1'b1),
    .power_up_reset_n_in(pwr_n), .master_clock_in(bclk),
    .slot_strobe_frame_pulse_in(strobe), .pcm_din_in(din),
    .pcm_dout_out(dout), .pcm_dout_oe_n_out(oe_n),
    .delayed_strobe_frame_out(dly),
    .law_pin_in(lp_oe_n ? law_pin : lp_o), .law_pin_out(lp_o),
    .law_pin_oe_n_out(lp_oe_n), .reg_req_in(req), .reg_rdata_out(rdata),
    .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
    .tx_sample_in(tx_sample), .rx_valid_out(rx_valid),
    .rx_sample_out(rx_sample), .cfg_out(cfg));

  pcmc_l1_model u_l1 (
    .bclk_out(bclk), .strobe_out(strobe), .din_out(din),
    .dout_in(dout), .oe_n_in(oe_n), .dly_in(dly));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string name, input logic [11:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys_in);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys_in);
    req <= '0;
  endtask

  // read data lands one edge after the read is taken
  task automatic rd(input logic [7:0] a, exp, input string name);
    @(posedge clk_sys_in);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys_in);
    req <= '0;
    @(posedge clk_sys_in);
    #1;
    chk(name, {4'h0, rdata}, {4'h0, exp});
  endtask

  task automatic do_reset();
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // cycle ceiling: six slots of 5000 cycles plus register traffic
  always @(posedge clk_sys_in)
  begin
    cycles++;
    rx_cnt += rx_valid;
    if (cycles == 45000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    do_reset();
    rd(8'h00, 8'h00, "fgc reset");
    rd(8'h01, 8'h03, "sgc reset");
    rd(8'h04, 8'hc0, "lpc reset");
    rd(8'h02, 8'h00, "unmapped");
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h77, "fgc");
    wr(8'h01, 8'h0e);
    rd(8'h01, 8'h0e, "sgc");
    // one slot per coding, law pin and mute setting
    for (k = 0; k < 6; k++)
    begin
      wr(8'h04, lpc[k]);
      wr(8'h03, (k == 5) ? 8'h03 : 8'h00);
      law_pin <= pin[k];
      tx_valid <= 1'b1;
      tx_sample <= txw[k];
      @(posedge clk_sys_in);
      tx_valid <= 1'b0;
      u_l1.frame(rxw[k], got, dly_n, drv_n);
      chk("tx", {4'h0, got}, {4'h0, txe[k]});
      chk("rx", {4'h0, rx_sample}, {4'h0, rxe[k]});
      chk("law", {11'h0, cfg.alaw}, {11'h0, law[k]});
      chk("dly", {4'h0, dly_n}, 12'h008);
      chk("release", {4'h0, drv_n}, 12'h000);
    end
    chk("cfg", cfg, {3'h7, 3'h7, 3'h6, 1'b1, 2'b00});
    // tdm with signalling enabled: delayed pulse, own channel, interrupt
    wr(8'h04, 8'hfc);
    u_l1.tdm_frame(dly_n, drv_n);
    chk("tdm dly", {4'h0, dly_n}, 12'h001);
    chk("tdm drive", {4'h0, drv_n}, 12'h010);
    chk("irq pin", {11'h0, lp_oe_n}, 12'h000);
    rd(8'h05, 8'h06, "status");
    chk("irq off", {11'h0, lp_oe_n}, 12'h001);
    chk("rx words", 12'(rx_cnt), 12'h007);
    pwr_n <= 1'b0;
    repeat (5) @(posedge clk_sys_in);
    pwr_n <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    rd(8'h01, 8'h03, "pwr sgc");
    rd(8'h04, 8'hc0, "pwr lpc");
    // fill the transmit buffer until it refuses
    do_reset();
    tx_valid <= 1'b1;
    n = 0;
    repeat (20)
    begin
      @(posedge clk_sys_in);
      n += tx_ready;
    end
    tx_valid <= 1'b0;
    chk("fifo depth", 12'(n), 12'h010);
    chk("fifo full", {11'h0, tx_ready}, 12'h000);
    wrap_up();
  end
endmodule
